// [torque_brake_safety.sv]
`timescale 1ns/1ps
`include "safety_defines.svh"

module torque_brake_safety #(
  parameter int unsigned FILTER_CYCLES  = `FILTER_CYCLES,
  parameter int unsigned DISCREP_CYCLES = `DISCREP_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               torque_req_a_n_i,
  input  wire logic               torque_req_b_n_i,
  input  wire logic               brake_req_a_n_i,
  input  wire logic               brake_req_b_n_i,
  input  wire logic               brake_open_cmd_i,
  input  wire logic               coupling_en_i,
  input  wire logic               fault_clear_i,
  output logic                    modulation_en_a_o,
  output logic                    modulation_en_b_o,
  output logic                    brake_high_side_o,
  output logic                    brake_low_side_o,
  output safety_pkg::status_t     status_o,
  output logic                    torque_removal_o,
  output logic                    brake_hold_function_o
);
  import safety_pkg::*;

  // Timing budget: a request crosses two synchroniser flops, sets the filtered
  // request flop and then the output flop, so entry costs four clock edges.
  // A release waits for the filter time on top of that, which keeps both
  // entry and release well inside the allowed reaction limits.
  // The filter only delays a release, never a request, so a glitch on a pin
  // can at worst stop the drive for one filter time; it never holds off a stop.

  // Counter widths follow the filter and discrepancy spans.
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam int DW = $clog2(DISCREP_CYCLES + 1);

  // Two-flop synchronisers on the four request pins (active low: 0 requests).
  // Reset loads zeros, so every channel starts out requesting the safe state
  // and the outputs only come up once the pins have been seen high long enough.
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync1_nxt;
  logic [3:0] sync2_nxt;

  always_comb begin
    sync1_nxt = {brake_req_b_n_i, brake_req_a_n_i, torque_req_b_n_i, torque_req_a_n_i};
    sync2_nxt = sync1_r;
    if (reset_i) begin
      sync1_nxt = 4'h0;
      sync2_nxt = 4'h0;
    end
  end

  // Synchroniser stages; only the second stage is read by the filters.
  always_ff @(posedge clk_i) begin
    sync1_r <= sync1_nxt;
    sync2_r <= sync2_nxt;
  end

  // Per-channel filter: a request is taken at once, a release only after it
  // stays stable for the filter time, so entry is immediate and exit bounded.
  // Indices 0 and 1 are the torque channels, 2 and 3 the brake channels.
  logic [3:0]  req_r;
  logic [3:0]  req_nxt;
  logic [CW-1:0] flt_r   [4];
  logic [CW-1:0] flt_nxt [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filter
      always_comb begin
        req_nxt[g] = req_r[g];
        flt_nxt[g] = '0;
        if (!sync2_r[g]) begin
          req_nxt[g] = 1'b1;
        end else if (req_r[g]) begin
          if (flt_r[g] >= CW'(FILTER_CYCLES - 1)) begin
            req_nxt[g] = 1'b0;
          end else begin
            flt_nxt[g] = flt_r[g] + CW'(1);
          end
        end
        if (reset_i) begin
          req_nxt[g] = 1'b1;
          flt_nxt[g] = '0;
        end
      end

      // Filtered request and its release counter.
      always_ff @(posedge clk_i) begin
        req_r[g] <= req_nxt[g];
        flt_r[g] <= flt_nxt[g];
      end
    end
  endgenerate

  // Returns high when the two channels of one function disagree.
  function automatic logic differs(input logic a, input logic b);
    return a ^ b;
  endfunction

  // Returns high when either channel of one function asks for the safe state.
  function automatic logic either_asks(input logic a, input logic b);
    return a | b;
  endfunction

  // Discrepancy watch per function; a lasting mismatch latches a fault.
  // A fault stays until the clear input is seen while both channels agree,
  // so a stuck channel keeps the drive in its safe state until it is mended.
  // Short mismatches from pin skew are tolerated by the wait state.
  chan_state_t   dst_r   [2];
  chan_state_t   dst_nxt [2];
  logic [DW-1:0] dcnt_r   [2];
  logic [DW-1:0] dcnt_nxt [2];

  generate
    for (g = 0; g < 2; g++) begin : g_discrep
      always_comb begin
        dst_nxt[g]  = dst_r[g];
        dcnt_nxt[g] = '0;
        unique case (dst_r[g])
          CH_IDLE: begin
            if (differs(req_r[2*g], req_r[2*g+1])) begin
              dst_nxt[g] = CH_WAIT;
            end
          end
          CH_WAIT: begin
            if (!differs(req_r[2*g], req_r[2*g+1])) begin
              dst_nxt[g] = CH_IDLE;
            end else if (dcnt_r[g] >= DW'(DISCREP_CYCLES - 1)) begin
              dst_nxt[g] = CH_FAULT;
            end else begin
              dcnt_nxt[g] = dcnt_r[g] + DW'(1);
            end
          end
          CH_FAULT: begin
            if (fault_clear_i && !differs(req_r[2*g], req_r[2*g+1])) begin
              dst_nxt[g] = CH_IDLE;
            end
          end
          default: dst_nxt[g] = CH_FAULT;
        endcase
        if (reset_i) begin
          dst_nxt[g]  = CH_IDLE;
          dcnt_nxt[g] = '0;
        end
      end

      // Discrepancy state and its counter.
      always_ff @(posedge clk_i) begin
        dst_r[g]  <= dst_nxt[g];
        dcnt_r[g] <= dcnt_nxt[g];
      end
    end
  endgenerate

  // Output decisions; a fault forces the safe state on both functions.
  // Torque removal overrides everything: no input can enable modulation while
  // either torque channel or a fault asks for the stop.
  // The brake open command is only honoured while nothing holds the brake.
  // With coupling on, any torque removal also holds the brake.
  logic    fault;
  logic    torque_off;
  logic    brake_hold;
  logic    mod_nxt;
  logic    mod_r;
  logic    brk_nxt;
  logic    brk_r;
  status_t stat_nxt;
  status_t stat_r;

  always_comb begin
    fault      = (dst_r[0] == CH_FAULT) || (dst_r[1] == CH_FAULT);
    torque_off = either_asks(req_r[0], req_r[1]) | fault;
    brake_hold = either_asks(req_r[2], req_r[3]) | fault | (coupling_en_i & torque_off);
    mod_nxt    = !torque_off;
    brk_nxt    = !brake_hold && brake_open_cmd_i;
    stat_nxt   = '0;
    stat_nxt[`STAT_ERROR_BIT]  = fault;
    stat_nxt[`STAT_TORQUE_BIT] = mod_nxt;
    stat_nxt[`STAT_BRAKE_BIT]  = brk_nxt;
    if (reset_i) begin
      mod_nxt  = 1'b0;
      brk_nxt  = 1'b0;
      stat_nxt = '0;
    end
  end

  // Output flops; reset leaves modulation off and the brake de-energised.
  always_ff @(posedge clk_i) begin
    mod_r  <= mod_nxt;
    brk_r  <= brk_nxt;
    stat_r <= stat_nxt;
  end

  // Both modulation enables and both brake switches follow the same decision;
  // either switch alone de-energises the brake, and low means engaged.
  // The diversity between the two switches lies in the power stage wiring.
  assign modulation_en_a_o     = mod_r;
  assign modulation_en_b_o     = mod_r;
  assign brake_high_side_o     = brk_r;
  assign brake_low_side_o      = brk_r;
  assign status_o              = stat_r;
  assign torque_removal_o      = !mod_r;
  assign brake_hold_function_o = !brk_r;
endmodule

// [safety_defines.svh]
`ifndef SAFETY_DEFINES_SVH
`define SAFETY_DEFINES_SVH

// Clock rate in kHz, used to turn millisecond limits into cycle counts.
`define CLK_FREQ_KHZ         200000
// Input filter time in microseconds; a released channel must stay high this long.
`define FILTER_TIME_US       1000
`define FILTER_CYCLES        ((`FILTER_TIME_US * `CLK_FREQ_KHZ) / 1000)
// Longest reaction times in milliseconds for the two functions.
`define TORQUE_ON_MAX_MS     4
`define TORQUE_OFF_MAX_MS    4
`define BRAKE_ON_MAX_MS      4
`define BRAKE_OFF_MAX_MS     5
// Channel disagreement allowed before a fault is latched, in milliseconds.
`define DISCREP_TIME_MS      20
`define DISCREP_CYCLES       (`DISCREP_TIME_MS * `CLK_FREQ_KHZ)
// Status word bit positions.
`define STAT_ERROR_BIT       0
`define STAT_TORQUE_BIT      1
`define STAT_BRAKE_BIT       2
`define STAT_WIDTH           3

`endif

// [safety_pkg.sv]
package safety_pkg;
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_WAIT,
    CH_FAULT
  } chan_state_t;
  typedef logic [2:0] status_t;
endpackage

// [tbs_chk.sv]
`timescale 1ns/1ps
module tbs_chk (
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire logic                torque_req_a_n_i,
  input wire logic                torque_req_b_n_i,
  input wire logic                brake_req_a_n_i,
  input wire logic                brake_req_b_n_i,
  input wire logic                brake_open_cmd_i,
  input wire logic                coupling_en_i,
  input wire logic                modulation_en_a_o,
  input wire logic                modulation_en_b_o,
  input wire logic                brake_high_side_o,
  input wire logic                brake_low_side_o,
  input wire safety_pkg::status_t status_o,
  input wire logic                torque_removal_o,
  input wire logic                brake_hold_function_o
);
  // All checks share the one clock and the synchronous reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Torque is cut on both enables and reported as removed.
  sequence s_cut;
    !modulation_en_a_o && !modulation_en_b_o && torque_removal_o;
  endsequence
  sequence s_held;
    brake_hold_function_o && !status_o[2];
  endsequence
  a_torque_entry: assert property ($fell(torque_req_a_n_i) |-> ##[1:4] s_cut)
    else $error("torque removal too late");
  a_torque_status: assert property (status_o[1] == modulation_en_a_o)
    else $error("torque status bit wrong");
  a_release_cause: assert property ($rose(modulation_en_b_o) |->
    $past(torque_req_a_n_i, 4) && $past(torque_req_b_n_i, 4))
    else $error("modulation back without release");
  a_switch_pair: assert property (brake_high_side_o == brake_low_side_o)
    else $error("brake switches disagree");
  a_brake_status: assert property (status_o[2] == brake_high_side_o)
    else $error("brake status bit wrong");
  a_hold_closed: assert property (brake_high_side_o |-> $past(brake_open_cmd_i) &&
    $past(brake_req_a_n_i, 4) && $past(brake_req_b_n_i, 4))
    else $error("brake open while held");
  a_brake_entry: assert property ($fell(brake_req_b_n_i) |-> ##[1:4] s_held)
    else $error("brake hold too late");
  a_couple_cut: assert property ($past(coupling_en_i) && torque_removal_o |->
    !brake_high_side_o)
    else $error("coupled brake not cut");
  a_fault_safe: assert property (status_o[0] |-> s_cut)
    else $error("fault without safe state");
endmodule
bind torque_brake_safety tbs_chk u_chk (.*);

// [safety_partner.sv]
`timescale 1ns/1ps
module safety_partner (
  input  wire logic clk_i,
  input  wire logic stop_i,
  input  wire logic hold_i,
  input  wire logic split_i,
  output logic      torque_a_n_o = 1'b0,
  output logic      torque_b_n_o = 1'b0,
  output logic      brake_a_n_o  = 1'b0,
  output logic      brake_b_n_o  = 1'b0
);
  // Switchgear pulls both channels low to ask; split inverts torque channel b.
  always @(posedge clk_i) begin
    torque_a_n_o <= !stop_i;
    torque_b_n_o <= !(stop_i ^ split_i);
    brake_a_n_o  <= !hold_i;
    brake_b_n_o  <= !hold_i;
  end
endmodule

// [tb_torque_brake_safety.sv]
`timescale 1ns/1ps
module tb_torque_brake_safety;
  import safety_pkg::*;
  logic clk_i = 0, reset_i = 1, stop = 1, hold = 1, split = 0, open = 0, couple = 0, clr = 0;
  logic ta_n, tb_n, ba_n, bb_n, mod_a, mod_b, hi, lo, trem, bhold;
  status_t stat;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  safety_partner far (.clk_i(clk_i), .stop_i(stop), .hold_i(hold), .split_i(split),
    .torque_a_n_o(ta_n), .torque_b_n_o(tb_n), .brake_a_n_o(ba_n), .brake_b_n_o(bb_n));
  torque_brake_safety #(.FILTER_CYCLES(4), .DISCREP_CYCLES(16)) dut (.clk_i(clk_i),
    .reset_i(reset_i), .torque_req_a_n_i(ta_n), .torque_req_b_n_i(tb_n),
    .brake_req_a_n_i(ba_n), .brake_req_b_n_i(bb_n), .brake_open_cmd_i(open),
    .coupling_en_i(couple), .fault_clear_i(clr), .modulation_en_a_o(mod_a),
    .modulation_en_b_o(mod_b), .brake_high_side_o(hi), .brake_low_side_o(lo),
    .status_o(stat), .torque_removal_o(trem), .brake_hold_function_o(bhold));
  task automatic chk(string n, logic [2:0] seen, logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Expected status word: brake open, torque allowed, fault.
  function automatic logic [2:0] exp_stat(logic f);
    return {!hold && open && !(couple && stop) && !f, !stop && !f, f};
  endfunction
  // Applies one set of requests, lets the filters settle, then compares.
  task automatic step(logic [4:0] r, logic f);
    logic [2:0] e;
    @(posedge clk_i);
    stop <= r[0] | (stop & !r[3]);
    hold <= r[1];
    open <= r[2];
    couple <= r[4];
    repeat (14) @(posedge clk_i);
    #1;
    e = exp_stat(f);
    chk("status", stat, e);
    chk("outputs", {trem, mod_a, lo}, {!e[1], e[1], e[2]});
    chk("pairs", {1'b0, mod_b, hi}, {1'b0, e[1], e[2]});
    chk("hold", {2'h0, bhold}, {2'h0, !e[2]});
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Corner cases, random traffic, then a latched channel fault.
  initial begin
    void'($urandom(78));
    repeat (20) @(posedge clk_i);
    reset_i <= 0;
    step(5'h0c, 0);
    step(5'h14, 0);
    step(5'h15, 0);
    repeat (40) step(5'($urandom), 0);
    @(posedge clk_i);
    split <= 1;
    repeat (30) @(posedge clk_i);
    step(5'h0c, 1);
    @(posedge clk_i);
    split <= 0;
    step(5'h0c, 1);
    @(posedge clk_i);
    clr <= 1;
    step(5'h0c, 0);
    stop_test();
  end
  // Cuts a hung run short.
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
endmodule
